// File: sfre_pkg.sv
package sfre_pkg;

    // Word width and storage depth of the buffer
    localparam int unsigned DATA_W     = 9;
    localparam int unsigned FIFO_DEPTH = 32;
    localparam int unsigned FIFO_AW    = 5;

    // Stored-word levels, one bit wider than the address
    localparam logic [5:0] LVL_EMPTY = 6'h00;
    localparam logic [5:0] LVL_FULL  = 6'h20;
    localparam logic [5:0] LVL_HALF  = 6'h10;
    localparam logic [5:0] AE_OFFSET = 6'h04;
    localparam logic [5:0] AF_OFFSET = 6'h04;
    localparam logic [5:0] LVL_AF    = LVL_FULL - AF_OFFSET;

    // Cycles of retransmit setup before reads are served again
    localparam logic [3:0] RW_SETUP_CYCLES = 4'h3;
    localparam logic [3:0] RW_IDLE         = 4'h0;

    // Mode loaded by nrst, before any master reset latches the strap
    localparam logic MODE_RST = 1'b0;

    // Status pins, all active low
    typedef struct packed {
        logic empty_n;
        logic out_ready_n;
        logic full_n;
        logic in_ready_n;
        logic ae_n;
        logic af_n;
        logic half_n;
    } sfre_flags_t;

    localparam sfre_flags_t FLAGS_RST = '{
        empty_n:     1'b0,
        out_ready_n: 1'b1,
        full_n:      1'b1,
        in_ready_n:  1'b0,
        ae_n:        1'b0,
        af_n:        1'b1,
        half_n:      1'b1
    };

endpackage

// File: sfre_fifo_mem.sv
`timescale 1ns/1ns
module sfre_fifo_mem #(
    parameter int unsigned WIDTH = 9,
    parameter int unsigned DEPTH = 32
) (
    input  wire logic                       clk,
    input  wire logic                       nrst,
    input  wire logic                       clear,
    input  wire logic                       rewind,
    input  wire logic                       in_valid,
    output logic                            in_ready,
    input  wire logic [WIDTH-1:0]           in_data,
    output logic                            out_valid,
    input  wire logic                       out_ready,
    output logic [WIDTH-1:0]                out_data,
    output logic [$clog2(DEPTH):0]          level
);
    localparam int unsigned AW = $clog2(DEPTH);
    localparam logic [AW:0] LVL_MAX = (AW+1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wptr_r;
    logic [AW-1:0]    rptr_r;
    logic [AW:0]      level_r;
    logic [AW:0]      level_nxt;
    logic [WIDTH-1:0] rd_data_r;
    wire              push;
    wire              pop;

    // Handshakes; full and empty come from the true level
    assign in_ready  = (level_r != LVL_MAX);
    assign out_valid = (level_r != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready && !rewind;
    assign out_data  = rd_data_r;
    assign level     = level_r;

    // Rewind replays everything written since the last clear, while that is under 32 words
    always_comb begin
        level_nxt = level_r;
        if (clear) begin
            level_nxt = '0;
        end else if (rewind) begin
            level_nxt = {1'b0, wptr_r} + {{AW{1'b0}}, push};
        end else begin
            level_nxt = level_r + {{AW{1'b0}}, push}
                                - {{AW{1'b0}}, pop};
        end
    end

    // Pointers and level; stored data is never touched by rewind
    always_ff @(posedge clk) begin
        if (!nrst || clear) begin
            wptr_r  <= '0;
            rptr_r  <= '0;
            level_r <= '0;
        end else begin
            level_r <= level_nxt;
            if (push) begin
                wptr_r <= wptr_r + 1'b1;
            end
            if (rewind) begin
                rptr_r <= '0;
            end else if (pop) begin
                rptr_r <= rptr_r + 1'b1;
            end
        end
    end

    // Storage array, no reset so it maps onto RAM
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wptr_r] <= in_data;
        end
    end

    // Registered read port
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rd_data_r <= '0;
        end else if (pop) begin
            rd_data_r <= mem[rptr_r];
        end
    end

endmodule

// File: sfre_top.sv
`timescale 1ns/1ns
// What this block does
// - Fall-through output word is excluded from the level behind partial flags.
// - Almost-empty deasserts one clock after the write that raises the level.
// - Almost-full deasserts one clock after the read that lowers the level.
// - Partial and half flags resume on the first memory read after retransmit setup.
// - In fall-through mode, output-ready goes low whenever a word sits in the output register.
// - Input-ready goes low whenever a free location exists.
// - After master or partial reset: empty memory, output-ready high.
module sfre_top
    import sfre_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire logic              master_reset_n,
    input  wire logic              partial_reset_n,
    input  wire logic              fall_through_mode,
    input  wire logic              write_en,
    input  wire logic [DATA_W-1:0] data_in,
    input  wire logic              read_en,
    input  wire logic              retransmit_strobe,
    output logic [DATA_W-1:0]      data_out,
    output logic                   empty_flag_n,
    output logic                   output_ready_n,
    output logic                   full_flag_n,
    output logic                   input_ready_n,
    output logic                   almost_empty_flag_n,
    output logic                   almost_full_flag_n,
    output logic                   half_full_flag_n
);

    logic              ftm_r;
    logic [3:0]        rw_cnt_r;
    logic [3:0]        rw_cnt_nxt;
    logic              hold_r;
    logic              pend_r;
    logic              out_full_r;
    logic              out_full_nxt;
    logic [DATA_W-1:0] data_out_r;
    sfre_flags_t       flags_r;
    sfre_flags_t       flags_nxt;

    logic              mem_in_ready;
    logic              mem_out_valid;
    logic [DATA_W-1:0] mem_out_data;
    logic [5:0]        level;

    wire               clear;
    wire               rw_busy;
    wire               rw_go;
    wire               rw_block;
    wire               pop_std;
    wire               pop_fall_through_mode;
    wire               pop;
    wire               out_take;
    wire               lvl_empty;
    wire               lvl_full;
    wire               lvl_ae;
    wire               lvl_af;
    wire               lvl_half;

    // Either reset empties the memory; only master reset reloads the mode
    assign clear    = !master_reset_n || !partial_reset_n;

    // Retransmit: a strobe during setup is ignored, no restart mid-setup
    assign rw_busy  = (rw_cnt_r != RW_IDLE);
    assign rw_go    = retransmit_strobe && !rw_busy && !clear;
    assign rw_block = rw_busy || retransmit_strobe;

    // Standard mode: a read on an empty memory is simply dropped
    assign pop_std  = !ftm_r && read_en && mem_out_valid && !rw_block;

    // Fall-through: refill the output register without a request;
    // one fetch in flight at a time keeps the ordering trivial
    assign pop_fall_through_mode = ftm_r && mem_out_valid && !pend_r && !rw_block
                      && (!out_full_r || read_en);
    assign pop      = pop_std || pop_fall_through_mode;
    assign out_take = ftm_r && read_en && out_full_r;

    // Level decode; level counts memory only, output register excluded
    assign lvl_empty = (level == LVL_EMPTY);
    assign lvl_full  = !mem_in_ready;       // Same term that drops writes
    assign lvl_ae    = (level <= AE_OFFSET);
    assign lvl_af    = (level >= LVL_AF);
    assign lvl_half  = (level > LVL_HALF);

    // Setup countdown after an accepted retransmit
    always_comb begin
        rw_cnt_nxt = rw_cnt_r;
        if (clear) begin
            rw_cnt_nxt = RW_IDLE;
        end else if (rw_go) begin
            rw_cnt_nxt = RW_SETUP_CYCLES;
        end else if (rw_busy) begin
            rw_cnt_nxt = rw_cnt_r - 4'h1;
        end
    end

    // Output register occupancy in fall-through mode
    always_comb begin
        out_full_nxt = out_full_r;
        if (clear || rw_go || !ftm_r) begin
            out_full_nxt = 1'b0;
        end else if (pend_r) begin
            out_full_nxt = 1'b1;
        end else if (out_take) begin
            out_full_nxt = 1'b0;
        end
    end

    // Flag next values
    always_comb begin
        flags_nxt = flags_r;
        // Held low through setup; high again marks setup complete
        flags_nxt.empty_n     = !lvl_empty && !rw_busy && !rw_go;
        // Low exactly while a word waits at the outputs
        flags_nxt.out_ready_n = !out_full_nxt;
        flags_nxt.full_n      = !lvl_full;
        // Low whenever at least one location is free
        flags_nxt.in_ready_n  = lvl_full;
        // Frozen from retransmit until the first location is read
        if (!hold_r) begin
            flags_nxt.ae_n = !lvl_ae;
            flags_nxt.af_n = !lvl_af;
            flags_nxt.half_n = !lvl_half;
        end
        if (clear) begin
            flags_nxt = FLAGS_RST;
        end
    end

    // Mode strap caught while master reset is low, never by nrst
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ftm_r <= MODE_RST;
        end else if (!master_reset_n) begin
            ftm_r <= fall_through_mode;
        end
    end

    // Retransmit sequencing and flag freeze
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rw_cnt_r <= RW_IDLE;
            hold_r   <= 1'b0;
        end else begin
            rw_cnt_r <= rw_cnt_nxt;
            if (clear) begin
                hold_r <= 1'b0;
            end else if (rw_go) begin
                hold_r <= 1'b1;
            end else if (pop) begin
                hold_r <= 1'b0;
            end
        end
    end

    // Fetch pipeline and output register
    always_ff @(posedge clk) begin
        if (!nrst) begin
            pend_r     <= 1'b0;
            out_full_r <= 1'b0;
        end else begin
            pend_r     <= pop && !clear;
            out_full_r <= out_full_nxt;
        end
    end

    // Data lands one clock after the memory read; later words stream
    // back to back in standard mode only; each fall-through word waits for its own fetch
    always_ff @(posedge clk) begin
        if (!nrst) begin
            data_out_r <= '0;
        end else if (pend_r && !clear) begin
            data_out_r <= mem_out_data;
        end
    end

    // Registered status pins
    always_ff @(posedge clk) begin
        if (!nrst) begin
            flags_r <= FLAGS_RST;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    // Storage; full back-pressure drops writes at the ready term
    sfre_fifo_mem #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_mem (
        .clk       (clk),
        .nrst      (nrst),
        .clear     (clear),
        .rewind    (rw_go),
        .in_valid  (write_en),
        .in_ready  (mem_in_ready),
        .in_data   (data_in),
        .out_valid (mem_out_valid),
        .out_ready (pop),
        .out_data  (mem_out_data),
        .level     (level)
    );

    // Pins straight from flops
    assign data_out            = data_out_r;
    assign empty_flag_n        = flags_r.empty_n;
    assign output_ready_n      = flags_r.out_ready_n;
    assign full_flag_n         = flags_r.full_n;
    assign input_ready_n       = flags_r.in_ready_n;
    assign almost_empty_flag_n = flags_r.ae_n;
    assign almost_full_flag_n  = flags_r.af_n;
    assign half_full_flag_n    = flags_r.half_n;

endmodule

// File: sfre_chk_properties.sv
`timescale 1ns/1ns
module sfre_chk
    import sfre_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic master_reset_n,
    input wire logic partial_reset_n,
    input wire logic fall_through_mode,
    input wire logic write_en,
    input wire logic read_en,
    input wire logic retransmit_strobe,
    input wire logic empty_flag_n,
    input wire logic output_ready_n,
    input wire logic full_flag_n,
    input wire logic input_ready_n,
    input wire logic almost_empty_flag_n,
    input wire logic almost_full_flag_n,
    input wire logic half_full_flag_n
);
    logic [11:0] wr_h;
    logic [11:0] rw_h;
    logic [3:0]  rd_h;
    logic [2:0]  rs_h;
    logic        mode_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // Short event histories; flags lag their cause by a few edges
    always_ff @(posedge clk) begin
        if (!nrst) begin
            wr_h   <= '0;
            rw_h   <= '0;
            rd_h   <= '0;
            rs_h   <= '0;
            mode_r <= 1'b0;
        end else begin
            wr_h <= {wr_h[10:0], write_en};
            rw_h <= {rw_h[10:0], retransmit_strobe};
            rd_h <= {rd_h[2:0], read_en};
            rs_h <= {rs_h[1:0], !master_reset_n || !partial_reset_n};
            if (!master_reset_n)
                mode_r <= fall_through_mode;
        end
    end

    a_ready_mirror: assert property (input_ready_n == !full_flag_n)
        else $error("input ready not inverse of full");
    a_reset_flags: assert property (!master_reset_n || !partial_reset_n |=>
        !empty_flag_n && output_ready_n && full_flag_n && input_ready_n == 0
        && !almost_empty_flag_n && almost_full_flag_n && half_full_flag_n)
        else $error("flags wrong after reset");
    a_ae_cause: assert property ($rose(almost_empty_flag_n) |-> |{wr_h, rw_h})
        else $error("almost empty rose without a write");
    a_af_cause: assert property ($rose(almost_full_flag_n) |-> |{rd_h, rs_h})
        else $error("almost full rose without a read");
    a_empty_cause: assert property ($rose(empty_flag_n) |-> |{wr_h, rw_h})
        else $error("empty flag rose without a cause");
    a_std_oready: assert property (!mode_r |-> output_ready_n)
        else $error("output ready low in standard mode");
    a_rewind_setup: assert property (retransmit_strobe |->
        ##2 (!empty_flag_n && output_ready_n) [*3])
        else $error("retransmit setup not held");
    a_half_ae: assert property (!half_full_flag_n |-> almost_empty_flag_n)
        else $error("half full while almost empty");
endmodule

// File: sfre_rd_model.sv
`timescale 1ns/1ns
module sfre_rd_model
    import sfre_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              go,
    input  wire logic              output_ready_n,
    input  wire logic [DATA_W-1:0] data_out,
    output logic                   read_en,
    output int                     got_cnt,
    output int                     got_sum
);
    int gap = 0;

    initial read_en = 1'b0;
    initial got_cnt = 0;
    initial got_sum = 0;

    // Takes only a presented word; gap skips the refetch window
    always @(negedge clk) begin
        read_en <= 1'b0;
        if (gap > 0)
            gap <= gap - 1;
        else if (go && output_ready_n === 1'b0) begin
            read_en <= 1'b1;
            got_cnt <= got_cnt + 1;
            got_sum <= got_sum + int'(data_out);
            gap     <= 2;
        end
    end
endmodule

// File: tb_top.sv
`timescale 1ns/1ns
module tb_top;
    import sfre_pkg::*;
    logic              clk = 1'b0;
    logic              nrst = 1'b0;
    logic              mst_n = 1'b1;
    logic              prt_n = 1'b1;
    logic              mode = 1'b0;
    logic              we = 1'b0;
    logic              rd_tb = 1'b0;
    logic              strobe = 1'b0;
    logic              go = 1'b0;
    logic [DATA_W-1:0] din = '0;
    logic [DATA_W-1:0] data_out;
    logic              rd_m;
    logic              emp_n, or_n, fl_n, in_n, ae_n, af_n, hl_n;
    // One-device group: composite flags reduce to the lone pin
    wire               grp_emp_n = &{emp_n};
    wire               grp_or_n  = |{or_n};
    sfre_flags_t       fl;
    int                got_cnt, got_sum, nw, nr, t;
    int                err_total = 0;
    int                cmp_count = 0;

    always #4 clk = ~clk;
    assign fl = {emp_n, or_n, fl_n, in_n, ae_n, af_n, hl_n};

    sfre_top DUT (.clk(clk), .nrst(nrst), .master_reset_n(mst_n),
        .partial_reset_n(prt_n), .fall_through_mode(mode), .write_en(we),
        .data_in(din), .read_en(rd_tb | rd_m), .retransmit_strobe(strobe),
        .data_out(data_out), .empty_flag_n(emp_n), .output_ready_n(or_n),
        .full_flag_n(fl_n), .input_ready_n(in_n), .almost_empty_flag_n(ae_n),
        .almost_full_flag_n(af_n), .half_full_flag_n(hl_n));
    sfre_rd_model u_rd (.clk(clk), .go(go), .output_ready_n(grp_or_n),
        .data_out(data_out), .read_en(rd_m), .got_cnt(got_cnt),
        .got_sum(got_sum));

    task automatic test_done();
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(string nm, logic [8:0] got, logic [8:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Back-to-back writes of a running count, then let flags settle
    task automatic fill(int n);
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            we = 1'b1;
            nw++;
            din = 9'(nw);
        end
        @(negedge clk);
        we = 1'b0;
        repeat (3) @(negedge clk);
    endtask

    task automatic rd1();
        @(negedge clk);
        rd_tb = 1'b1;
        @(negedge clk);
        rd_tb = 1'b0;
        nr++;
        repeat (2) @(negedge clk);
        chk("data_out", data_out, 9'(nr));
    endtask

    task automatic mreset(logic m, logic part);
        @(negedge clk);
        mst_n = part;
        prt_n = !part;
        mode = m;
        @(negedge clk);
        mst_n = 1'b1;
        prt_n = 1'b1;
        nw = 0;
        nr = 0;
        chk("flags", 9'(fl), 9'(FLAGS_RST));
    endtask

    // Pulse retransmit, then hold off until setup ends
    task automatic rewind();
        @(negedge clk);
        strobe = 1'b1;
        @(negedge clk);
        strobe = 1'b0;
        nr = 0;
        // Writer and reader both hold off until setup ends
        for (t = 0; t < 20 && (mode ? grp_or_n !== 1'b0
                                    : grp_emp_n !== 1'b1); t++)
            @(negedge clk);
    endtask

    initial begin
        #200000;
        err_total++;
        test_done();
    end

    initial begin
        repeat (3) @(negedge clk);
        chk("flags", 9'(fl), 9'(FLAGS_RST));
        nrst = 1'b1;
        mreset(1'b0, 1'b0);
        fill(4);
        chk("flags", 9'(fl), 9'h073);
        fill(1);
        chk("flags", 9'(fl), 9'h077);
        fill(12);
        chk("flags", 9'(fl), 9'h076);
        fill(11);
        chk("flags", 9'(fl), 9'h074);
        fill(5);
        chk("flags", 9'(fl), 9'h06c);
        for (int k = 0; k < 32; k++) begin
            rd1();
            if (nr == 5)
                chk("flags", 9'(fl), 9'h076);
            if (nr == 16)
                chk("flags", 9'(fl), 9'h077);
        end
        chk("flags", 9'(fl), 9'h033);
        // Standard retransmit replays from the first word
        mreset(1'b0, 1'b0);
        fill(3);
        repeat (3) rd1();
        rewind();
        chk("empty_flag_n", 9'(emp_n), 9'h001);
        repeat (3) rd1();
        // Fall-through: first word lands in the output register
        mreset(1'b1, 1'b0);
        fill(1);
        chk("data_out", data_out, 9'h001);
        chk("flags", 9'(fl), 9'h013);
        fill(4);
        chk("flags", 9'(fl), 9'h053);
        fill(1);
        chk("flags", 9'(fl), 9'h057);
        go = 1'b1;
        repeat (30) @(negedge clk);
        chk("count", 9'(got_cnt), 9'h006);
        chk("sum", 9'(got_sum), 9'h015);
        chk("flags", 9'(fl), 9'h033);
        go = 1'b0;
        rewind();
        chk("output_ready_n", 9'(or_n), 9'h000);
        go = 1'b1;
        repeat (30) @(negedge clk);
        chk("count", 9'(got_cnt), 9'h00c);
        chk("sum", 9'(got_sum), 9'h02a);
        go = 1'b0;
        // Partial reset empties memory but keeps fall-through mode
        mreset(1'b0, 1'b1);
        fill(1);
        chk("flags", 9'(fl), 9'h013);
        test_done();
    end
endmodule

bind sfre_top sfre_chk u_chk (.clk(clk), .nrst(nrst),
    .master_reset_n(master_reset_n), .partial_reset_n(partial_reset_n),
    .fall_through_mode(fall_through_mode), .write_en(write_en),
    .read_en(read_en), .retransmit_strobe(retransmit_strobe),
    .empty_flag_n(empty_flag_n), .output_ready_n(output_ready_n),
    .full_flag_n(full_flag_n), .input_ready_n(input_ready_n),
    .almost_empty_flag_n(almost_empty_flag_n),
    .almost_full_flag_n(almost_full_flag_n),
    .half_full_flag_n(half_full_flag_n));
